/* File: shared/twt_pkg.sv */
// Purpose: shared constants and carrier types of the tilt and wrist tilt detector
// Assumes: register index times four is the byte address on the bus
// Notes:   the control and flag bit positions and every nonzero reset value used by the design live here
package twt_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ROUTE_CFG = 8'h0b;
  localparam logic [7:0] IDX_CTRL      = 8'h19;
  localparam logic [7:0] IDX_SRC2      = 8'h54;
  localparam logic [7:0] IDX_AXIS_STAT = 8'h55;
  localparam logic [7:0] IDX_TILT_WIN  = 8'h60;
  localparam logic [7:0] IDX_TILT_THR  = 8'h61;
  localparam logic [7:0] IDX_AXIS_SEL  = 8'h62;
  localparam logic [7:0] IDX_WRIST_THR = 8'h63;
  localparam logic [7:0] IDX_WRIST_LAT = 8'h64;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h65;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h66;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned FN_ENABLE_BIT = 2;
  localparam int unsigned TILT_EN_BIT   = 3;
  localparam int unsigned WRIST_EN_BIT  = 7;
  localparam int unsigned ROUTE_BIT     = 0;
  localparam int unsigned SRC2_FLAG_BIT = 0;
  localparam int unsigned IRQ_TILT_BIT  = 0;
  localparam int unsigned IRQ_WRIST_BIT = 1;
  localparam int unsigned ADDR_LSB      = 2;
  localparam int unsigned ADDR_IDX_MSB  = 9;
  localparam int unsigned THR_SHIFT     = 6;
  localparam int unsigned AXIS_NUM      = 6;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [5:0] AXIS_SEL_RST  = 6'h01;
  localparam logic [7:0] WRIST_THR_RST = 8'h80;
  localparam logic [7:0] WRIST_LAT_RST = 8'h01;
  localparam logic [7:0] TILT_THR_RST  = 8'h20;
  localparam logic [2:0] TILT_WIN_RST  = 3'h4;
  localparam logic [7:0] LAT_MIN       = 8'h01;
  localparam logic [7:0] CNT_MAX       = 8'hff;

  // ----------------------------------------------------------------
  // timing and bus codes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned EVAL_HZ  = 26;
  localparam int unsigned EVAL_DIV = CLK_HZ / EVAL_HZ;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic        HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][15:0] axis;
  } twt_accel_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] idx;
  } twt_rd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] idx;
    logic [7:0] wdata;
  } twt_wr_t;

  typedef enum logic [1:0] {
    AHB_IDLE    = 2'b00,
    AHB_RD_WAIT = 2'b01,
    AHB_RD_DATA = 2'b10
  } twt_ahb_state_t;

  typedef struct packed {
    twt_ahb_state_t state;
    logic [7:0]     idx;
    logic           in_map;
    logic           wr_pend;
    logic [31:0]    hrdata;
  } twt_ahb_st_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } twt_div_st_t;

  typedef struct packed {
    logic [7:0]                  route;
    logic [7:0]                  ctrl;
    logic                        wrist_flag;
    logic [AXIS_NUM-1:0]         axis_hit;
    logic [2:0]                  tilt_win;
    logic [7:0]                  tilt_thr;
    logic [AXIS_NUM-1:0]         axis_sel;
    logic [7:0]                  wrist_thr;
    logic [7:0]                  wrist_lat;
    logic [1:0]                  irq_st;
    logic [1:0]                  irq_mask;
    logic                        irq;
    logic                        pin_two;
    twt_accel_t                  sample;
    logic [6:0]                  win_cnt;
    logic [2:0][22:0]            sum;
    logic [2:0][15:0]            ref_v;
    logic                        ref_ok;
    logic [AXIS_NUM-1:0][7:0]    lat_cnt;
  } twt_core_st_t;

endpackage

/* File: core/twt_tick_div.sv */
// Purpose: one-cycle evaluation tick from the core clock
// Assumes: DIV core cycles per tick
// Notes:   tick is registered
`timescale 1ns/1ns
`default_nettype none
module twt_tick_div #(
  parameter int unsigned DIV = twt_pkg::EVAL_DIV
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  twt_pkg::twt_div_st_t st_r;
  twt_pkg::twt_div_st_t st_nxt;

  if (DIV < 2) begin : g_chk
    $error("twt_tick_div: DIV must be at least 2");
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (rst_in) begin
      st_nxt = '0;
    end else if (st_r.cnt == 32'(DIV - 1)) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign tick_out = st_r.tick;

endmodule
`default_nettype wire

/* File: core/twt_ahb_slave.sv */
// Purpose: AHB-Lite slave front end for the detector registers
// Assumes: single slave, word transfers, hready is this slave's hreadyout
// Notes:   writes take no wait state, reads take one
`timescale 1ns/1ns
`default_nettype none
module twt_ahb_slave (
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  input  wire logic                hsel_in,
  input  wire logic [31:0]         haddr_in,
  input  wire logic [1:0]          htrans_in,
  input  wire logic                hwrite_in,
  input  wire logic [2:0]          hsize_in,
  input  wire logic [31:0]         hwdata_in,
  input  wire logic                hready_in,
  output logic [31:0]              hrdata_out,
  output logic                     hreadyout_out,
  output logic                     hresp_out,
  output twt_pkg::twt_rd_t         rd_out,
  output twt_pkg::twt_wr_t         wr_out,
  input  wire logic [7:0]          rd_data_in
);

  twt_pkg::twt_ahb_st_t st_r;
  twt_pkg::twt_ahb_st_t st_nxt;
  logic                 accept;
  logic                 in_map;

  assign accept = hsel_in && hready_in && htrans_in[twt_pkg::HTRANS_ACTIVE_BIT];
  assign in_map = (haddr_in[31:twt_pkg::ADDR_IDX_MSB+1] == '0)
               && (hsize_in == twt_pkg::HSIZE_WORD);

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_pend = 1'b0;
    if (rst_in) begin
      st_nxt = '0;
      st_nxt.state = twt_pkg::AHB_IDLE;
    end else begin
      unique case (st_r.state)
        twt_pkg::AHB_RD_WAIT: begin
          st_nxt.hrdata = st_r.in_map ? {24'h0, rd_data_in} : 32'h0;
          st_nxt.state = twt_pkg::AHB_RD_DATA;
        end
        twt_pkg::AHB_IDLE, twt_pkg::AHB_RD_DATA: begin
          st_nxt.state = twt_pkg::AHB_IDLE;
          if (accept) begin
            st_nxt.idx = haddr_in[twt_pkg::ADDR_IDX_MSB:twt_pkg::ADDR_LSB];
            st_nxt.in_map = in_map;
            if (hwrite_in) begin
              st_nxt.wr_pend = in_map;
            end else begin
              st_nxt.state = twt_pkg::AHB_RD_WAIT;
            end
          end
        end
        default: begin
          st_nxt.state = twt_pkg::AHB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign hrdata_out = st_r.hrdata;
  assign hreadyout_out = (st_r.state != twt_pkg::AHB_RD_WAIT);
  assign hresp_out = twt_pkg::HRESP_OKAY;
  assign rd_out.valid = (st_r.state == twt_pkg::AHB_RD_WAIT) && st_r.in_map;
  assign rd_out.idx = st_r.idx;
  assign wr_out.valid = st_r.wr_pend;
  assign wr_out.idx = st_r.idx;
  assign wr_out.wdata = hwdata_in[7:0];

endmodule
`default_nettype wire

/* File: core/twt_detector.sv */
// Purpose: tilt change and wrist tilt event detector with AHB-Lite registers
// Assumes: samples come from same-clock logic, 1 g near 16384 counts
// Notes:   both detectors evaluate on the 26 Hz tick with the latest sample
//
// Function
// - raise tilt event when orientation changes
// - tilt uses programmable window and threshold
// - wrist compares chosen semi-axis against limit
// - wrist threshold sets angle, latency sets duration
// - wrist fires after angle held for latency
// - wrist evaluates accelerometer at 26 Hz
// - positive X semi-axis selected after reset
// - wrist runs only with both enables set
// - routing bit drives wrist event to pin two
// - wrist flag readable, read clears latched event
// - axis status shows which semi-axis fired
`timescale 1ns/1ns
`default_nettype none
module twt_detector #(
  parameter int unsigned EVAL_DIV = twt_pkg::EVAL_DIV
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  input  wire logic                hsel_in,
  input  wire logic [31:0]         haddr_in,
  input  wire logic [1:0]          htrans_in,
  input  wire logic                hwrite_in,
  input  wire logic [2:0]          hsize_in,
  input  wire logic [31:0]         hwdata_in,
  input  wire logic                hready_in,
  output logic [31:0]              hrdata_out,
  output logic                     hreadyout_out,
  output logic                     hresp_out,
  input  wire logic                sample_valid_in,
  input  wire twt_pkg::twt_accel_t sample_in,
  output logic                     pin_two_out,
  output logic                     irq_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [16:0] sext17(logic [15:0] a);
    return {a[15], a};
  endfunction

  function automatic logic signed [16:0] semi_val(twt_pkg::twt_accel_t smp,
                                                 int unsigned k);
    logic signed [16:0] v;
    v = sext17(smp.axis[k/2]);
    return (k % 2 == 1) ? -v : v;
  endfunction

  function automatic logic [16:0] mag17(logic signed [16:0] d);
    return d[16] ? 17'(-d) : 17'(d);
  endfunction

  function automatic logic [16:0] scale_thr(logic [7:0] t);
    return 17'(t) << twt_pkg::THR_SHIFT;
  endfunction

  function automatic logic [7:0] read_reg(twt_pkg::twt_core_st_t s,
                                          logic [7:0] idx);
    logic [7:0] d;
    d = 8'h00;
    case (idx)
      twt_pkg::IDX_ROUTE_CFG: d = s.route;
      twt_pkg::IDX_CTRL:      d = s.ctrl;
      twt_pkg::IDX_SRC2:      d = 8'(s.wrist_flag) << twt_pkg::SRC2_FLAG_BIT;
      twt_pkg::IDX_AXIS_STAT: d = 8'(s.axis_hit);
      twt_pkg::IDX_TILT_WIN:  d = 8'(s.tilt_win);
      twt_pkg::IDX_TILT_THR:  d = s.tilt_thr;
      twt_pkg::IDX_AXIS_SEL:  d = 8'(s.axis_sel);
      twt_pkg::IDX_WRIST_THR: d = s.wrist_thr;
      twt_pkg::IDX_WRIST_LAT: d = s.wrist_lat;
      twt_pkg::IDX_IRQ_STAT:  d = 8'(s.irq_st);
      twt_pkg::IDX_IRQ_MASK:  d = 8'(s.irq_mask);
      default:                d = 8'h00;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  twt_pkg::twt_core_st_t st_r;
  twt_pkg::twt_core_st_t st_nxt;
  twt_pkg::twt_rd_t      rd;
  twt_pkg::twt_wr_t      wr;
  logic [7:0]            rd_data;
  logic                  eval_tick;
  logic                  func_on;
  logic                  wrist_on;
  logic                  tilt_on;
  logic [7:0]            lat_eff;
  logic [5:0]            above;
  logic [5:0]            wrist_hit;
  logic                  wrist_evt;
  logic                  tilt_evt;
  logic                  win_end;
  logic [6:0]            win_last;

  twt_ahb_slave u_bus (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hready_in),
    .hrdata_out    (hrdata_out),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .rd_out        (rd),
    .wr_out        (wr),
    .rd_data_in    (rd_data)
  );

  twt_tick_div #(
    .DIV (EVAL_DIV)
  ) u_div (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tick_out    (eval_tick)
  );

  assign rd_data = read_reg(st_r, rd.idx);

  // ----------------------------------------------------------------
  // enables and derived values
  // ----------------------------------------------------------------
  assign func_on  = st_r.ctrl[twt_pkg::FN_ENABLE_BIT];
  assign wrist_on = func_on && st_r.ctrl[twt_pkg::WRIST_EN_BIT];
  assign tilt_on  = func_on && st_r.ctrl[twt_pkg::TILT_EN_BIT];
  assign lat_eff  = (st_r.wrist_lat < twt_pkg::LAT_MIN) ? twt_pkg::LAT_MIN
                  : st_r.wrist_lat;
  assign win_last = 7'((8'h01 << st_r.tilt_win) - 8'h01);
  assign win_end  = (st_r.win_cnt == win_last);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [16:0] avg;
    logic               big;
    st_nxt = st_r;
    avg = '0;
    big = 1'b0;
    above = '0;
    wrist_hit = '0;
    tilt_evt = 1'b0;
    if (sample_valid_in) begin
      st_nxt.sample = sample_in;
    end

    // wrist angle per semi-axis
    for (int unsigned k = 0; k < twt_pkg::AXIS_NUM; k++) begin
      // angle above limit on this semi-axis
      above[k] = semi_val(st_r.sample, k)
               > $signed(scale_thr(st_r.wrist_thr));
      if (!wrist_on || !st_r.axis_sel[k]) begin
        st_nxt.lat_cnt[k] = '0;
      end else if (eval_tick) begin
        if (above[k]) begin
          if (st_r.lat_cnt[k] != twt_pkg::CNT_MAX) begin
            st_nxt.lat_cnt[k] = st_r.lat_cnt[k] + 8'h01;
          end
          // once per episode, when held for the latency
          wrist_hit[k] = (st_r.lat_cnt[k] == lat_eff - 8'h01);
        end else begin
          st_nxt.lat_cnt[k] = '0;
        end
      end
    end
    wrist_evt = |wrist_hit;

    // tilt change by windowed average
    if (!tilt_on) begin
      st_nxt.win_cnt = '0;
      st_nxt.sum = '0;
      st_nxt.ref_ok = 1'b0;
    end else if (eval_tick) begin
      for (int unsigned a = 0; a < 3; a++) begin
        st_nxt.sum[a] = st_r.sum[a]
                      + 23'({{7{st_r.sample.axis[a][15]}}, st_r.sample.axis[a]});
      end
      if (win_end) begin
        for (int unsigned a = 0; a < 3; a++) begin
          avg = sext17(16'($signed(st_nxt.sum[a]) >>> st_r.tilt_win));
          if (mag17(avg - sext17(st_r.ref_v[a])) > scale_thr(st_r.tilt_thr)) begin
            big = 1'b1;
          end
        end
        // first window only fixes the reference
        tilt_evt = st_r.ref_ok && big;
        if (!st_r.ref_ok || big) begin
          for (int unsigned a = 0; a < 3; a++) begin
            st_nxt.ref_v[a] = 16'($signed(st_nxt.sum[a]) >>> st_r.tilt_win);
          end
        end
        st_nxt.ref_ok = 1'b1;
        st_nxt.sum = '0;
        st_nxt.win_cnt = '0;
      end else begin
        st_nxt.win_cnt = st_r.win_cnt + 7'h01;
      end
    end

    // software writes
    if (wr.valid) begin
      case (wr.idx)
        twt_pkg::IDX_ROUTE_CFG: st_nxt.route = wr.wdata;
        twt_pkg::IDX_CTRL:      st_nxt.ctrl = wr.wdata;
        twt_pkg::IDX_TILT_WIN:  st_nxt.tilt_win = wr.wdata[2:0];
        twt_pkg::IDX_TILT_THR:  st_nxt.tilt_thr = wr.wdata;
        twt_pkg::IDX_AXIS_SEL:  st_nxt.axis_sel = wr.wdata[5:0];
        twt_pkg::IDX_WRIST_THR: st_nxt.wrist_thr = wr.wdata;
        twt_pkg::IDX_WRIST_LAT: st_nxt.wrist_lat = wr.wdata;
        twt_pkg::IDX_IRQ_STAT:  st_nxt.irq_st = st_r.irq_st & ~wr.wdata[1:0];
        twt_pkg::IDX_IRQ_MASK:  st_nxt.irq_mask = wr.wdata[1:0];
        default: begin
        end
      endcase
    end

    // read side effect, then events win over clears
    if (rd.valid && rd.idx == twt_pkg::IDX_SRC2) begin
      st_nxt.wrist_flag = 1'b0;
    end
    if (wrist_evt) begin
      st_nxt.wrist_flag = 1'b1;
      st_nxt.axis_hit = wrist_hit;
      st_nxt.irq_st[twt_pkg::IRQ_WRIST_BIT] = 1'b1;
    end
    if (tilt_evt) begin
      st_nxt.irq_st[twt_pkg::IRQ_TILT_BIT] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
    st_nxt.pin_two = st_nxt.route[twt_pkg::ROUTE_BIT] && st_nxt.wrist_flag;

    if (rst_in) begin
      st_nxt = '0;
      st_nxt.axis_sel = twt_pkg::AXIS_SEL_RST;
      st_nxt.wrist_thr = twt_pkg::WRIST_THR_RST;
      st_nxt.wrist_lat = twt_pkg::WRIST_LAT_RST;
      st_nxt.tilt_thr = twt_pkg::TILT_THR_RST;
      st_nxt.tilt_win = twt_pkg::TILT_WIN_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign pin_two_out = st_r.pin_two;
  assign irq_out  = st_r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_tilt_window: assert property (
    tilt_evt |-> (win_end && eval_tick && st_r.ref_ok))
    else $error("tilt event outside a window end");

  a_tilt_status: assert property (
    tilt_evt |=> (st_r.irq_st[twt_pkg::IRQ_TILT_BIT] && $past(tilt_on)))
    else $error("tilt event not recorded or not enabled");

  a_semi_axis: assert property (
    (wrist_hit & ~(st_r.axis_sel & above)) == '0)
    else $error("wrist hit on unselected or low axis");

  a_lat_count: assert property (
    (eval_tick && wrist_on && st_r.axis_sel[0] && above[0]
     && st_r.lat_cnt[0] != twt_pkg::CNT_MAX)
    |=> st_r.lat_cnt[0] == $past(st_r.lat_cnt[0]) + 8'h01)
    else $error("latency counter did not advance");

  a_wrist_latency: assert property (
    wrist_hit[0] |-> (st_r.lat_cnt[0] == lat_eff - 8'h01))
    else $error("wrist event before latency elapsed");

  a_eval_rate: assert property (
    wrist_evt |-> eval_tick)
    else $error("wrist event off the evaluation tick");

  a_axis_default: assert property (
    $past(rst_in) |-> st_r.axis_sel == twt_pkg::AXIS_SEL_RST)
    else $error("axis select not positive x after reset");

  a_wrist_enable: assert property (
    wrist_evt |-> (st_r.ctrl[twt_pkg::FN_ENABLE_BIT]
                   && st_r.ctrl[twt_pkg::WRIST_EN_BIT]))
    else $error("wrist event while disabled");

  a_pin_two_route: assert property (
    (wrist_evt && st_nxt.route[twt_pkg::ROUTE_BIT]) |=> pin_two_out)
    else $error("routed wrist event missing on pin two");

  a_src2_clear: assert property (
    (rd.valid && rd.idx == twt_pkg::IDX_SRC2 && !wrist_evt)
    |=> (!st_r.wrist_flag && !pin_two_out))
    else $error("flag not cleared by read");

  a_axis_report: assert property (
    wrist_evt |=> st_r.axis_hit == $past(wrist_hit))
    else $error("axis status does not match event");

  a_lat_write: assert property (
    (wr.valid && wr.idx == twt_pkg::IDX_WRIST_LAT)
    |=> st_r.wrist_lat == $past(wr.wdata))
    else $error("latency write not stored");

  a_wrist_off_clear: assert property (
    !wrist_on |=> st_r.lat_cnt == '0)
    else $error("latency counters kept while disabled");

  a_tilt_off_clear: assert property (
    !tilt_on |=> (st_r.win_cnt == '0 && !st_r.ref_ok))
    else $error("tilt window kept while disabled");

  a_lat_restart: assert property (
    (eval_tick && wrist_on && st_r.axis_sel[0] && !above[0])
    |=> st_r.lat_cnt[0] == '0)
    else $error("latency counter not restarted below limit");

  a_pin_two_off: assert property (
    !st_r.route[twt_pkg::ROUTE_BIT] |-> !pin_two_out)
    else $error("pin two driven while not routed");

  c_wrist_evt: cover property (wrist_evt ##1 pin_two_out);
  c_axis_neg: cover property (wrist_evt && wrist_hit[3]);
  c_tilt_evt: cover property (tilt_evt ##1 irq_out);
  c_read_clear: cover property (
    st_r.wrist_flag && rd.valid && rd.idx == twt_pkg::IDX_SRC2);

endmodule
`default_nettype wire

/* File: tb/twt_accel_src.sv */
// Purpose: accelerometer sample source feeding the detector
// Assumes: one sample every PERIOD core cycles, faster than the eval tick
// Notes:   between pulses the data lines show the inverse of the value
`timescale 1ns/1ns
`default_nettype none
module twt_accel_src #(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  input  wire twt_pkg::twt_accel_t value_in,
  output logic                     valid_out,
  output twt_pkg::twt_accel_t      sample_out
);
  logic [7:0] cnt_r;
  logic       hit;
  assign hit = (cnt_r == 8'(PERIOD - 1));
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_r      <= '0;
      valid_out  <= 1'b0;
      sample_out <= '0;
    end else begin
      cnt_r      <= hit ? 8'h00 : cnt_r + 8'h01;
      valid_out  <= hit;
      sample_out <= hit ? value_in : ~value_in;
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: register-level tests of the tilt and wrist tilt detector
// Assumes: eval tick every 8 core cycles, samples every 4
// Notes:   AHB-Lite master tasks wait on hready, watchdog cuts hangs
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                hsel = 1'b0;
  logic                hwrite = 1'b0;
  logic [1:0]          htrans = 2'b00;
  logic [31:0]         haddr = '0;
  logic [31:0]         hwdata = '0;
  logic [31:0]         hrdata;
  logic [31:0]         rv;
  logic                hready;
  logic                sv;
  logic                pin_two;
  logic                hresp;
  logic                irq;
  twt_pkg::twt_accel_t smp;
  twt_pkg::twt_accel_t acc = '0;
  int                  err_count = 0;
  int                  n_compared = 0;

  always #10 clk = ~clk;

  twt_detector #(.EVAL_DIV(8)) dut (
    .core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(twt_pkg::HSIZE_WORD),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .sample_valid_in(sv),
    .sample_in(smp), .pin_two_out(pin_two), .irq_out(irq));

  twt_accel_src src (
    .core_clk_in(clk), .rst_in(rst), .value_in(acc),
    .valid_out(sv), .sample_out(smp));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // data phase ends at the edge where hready is high
  task wait_rdy;
    @(negedge clk);
    while (hready !== 1'b1) begin
      @(negedge clk);
    end
    rv = hrdata;
    @(posedge clk);
  endtask

  task acc_bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'b00};
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    acc_bus(idx, 1'b1, d);
  endtask

  task rc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    acc_bus(idx, 1'b0, 8'h00);
    chk(nm, rv, {24'h0, e});
    chk({nm, "_resp"}, {31'h0, hresp}, 32'h0);
    @(negedge clk);
  endtask

  task ticks(input int n);
    repeat (8 * n) @(posedge clk);
    @(negedge clk);
  endtask

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(twt_pkg::IDX_AXIS_SEL, 8'h01, "axis_sel");
    rc(twt_pkg::IDX_WRIST_THR, 8'h80, "wrist_thr");
    rc(twt_pkg::IDX_WRIST_LAT, 8'h01, "wrist_lat");
    wr(twt_pkg::IDX_WRIST_LAT, 8'h03);
    rc(twt_pkg::IDX_WRIST_LAT, 8'h03, "wrist_lat_wr");
    rc(twt_pkg::IDX_TILT_WIN, 8'h04, "tilt_win");
    rc(twt_pkg::IDX_TILT_THR, 8'h20, "tilt_thr");
    rc(8'h3f, 8'h00, "unmapped");
    $display("test registers done");
    acc.axis[0] <= 16'h4000;
    wr(twt_pkg::IDX_ROUTE_CFG, 8'h01);
    wr(twt_pkg::IDX_IRQ_MASK, 8'h02);
    wr(twt_pkg::IDX_CTRL, 8'h80);
    ticks(5);
    rc(twt_pkg::IDX_SRC2, 8'h00, "one_enable");
    wr(twt_pkg::IDX_CTRL, 8'h84);
    ticks(2);
    chk("pin_two_early", {31'h0, pin_two}, 32'h0);
    ticks(2);
    chk("pin_two_set", {31'h0, pin_two}, 32'h1);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rc(twt_pkg::IDX_SRC2, 8'h01, "flag");
    rc(twt_pkg::IDX_SRC2, 8'h00, "flag_clr");
    @(negedge clk);
    chk("pin_two_clr", {31'h0, pin_two}, 32'h0);
    rc(twt_pkg::IDX_AXIS_STAT, 8'h01, "axis_px");
    wr(twt_pkg::IDX_IRQ_STAT, 8'h02);
    rc(twt_pkg::IDX_IRQ_STAT, 8'h00, "irq_stat_clr");
    chk("irq_clr", {31'h0, irq}, 32'h0);
    $display("test wrist latency done");
    acc.axis[0] <= 16'h2000;
    wr(twt_pkg::IDX_WRIST_LAT, 8'h01);
    ticks(4);
    rc(twt_pkg::IDX_SRC2, 8'h00, "at_thr");
    acc.axis[1] <= 16'hc000;
    wr(twt_pkg::IDX_ROUTE_CFG, 8'h00);
    wr(twt_pkg::IDX_AXIS_SEL, 8'h08);
    ticks(4);
    chk("pin_two_unrouted", {31'h0, pin_two}, 32'h0);
    rc(twt_pkg::IDX_SRC2, 8'h01, "neg_y");
    rc(twt_pkg::IDX_AXIS_STAT, 8'h08, "axis_ny");
    $display("test wrist axis done");
    wr(twt_pkg::IDX_TILT_WIN, 8'h00);
    wr(twt_pkg::IDX_TILT_THR, 8'h10);
    wr(twt_pkg::IDX_IRQ_MASK, 8'h01);
    wr(twt_pkg::IDX_CTRL, 8'h0c);
    wr(twt_pkg::IDX_IRQ_STAT, 8'h03);
    ticks(4);
    acc.axis[0] <= 16'h2300;
    ticks(4);
    rc(twt_pkg::IDX_IRQ_STAT, 8'h00, "tilt_small");
    chk("irq_quiet", {31'h0, irq}, 32'h0);
    acc.axis[1] <= 16'h0000;
    ticks(4);
    rc(twt_pkg::IDX_IRQ_STAT, 8'h01, "tilt_big");
    chk("irq_tilt", {31'h0, irq}, 32'h1);
    $display("test tilt done");
    give_verdict;
  end
endmodule
`default_nettype wire
